// >>> rtl/tmc_pkg.sv
// Shared constants and types of the 8/16-bit timer/counter
package tmc_pkg;

  // ==========================================================
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] OFS_COUNT_LOW = 5'h00;
  localparam logic [4:0] OFS_PERIOD_HBUF = 5'h04;
  localparam logic [4:0] OFS_CTRL_ZERO = 5'h08;
  localparam logic [4:0] OFS_CTRL_ONE = 5'h0C;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // ==========================================================
  // Field positions
  localparam int CZ_ENABLE_BIT = 7;
  localparam int CZ_TOGGLE_BIT = 5;
  localparam int CZ_WIDE_BIT = 4;
  localparam int CO_SRC_LSB = 5;
  localparam int CO_UNSYNC_BIT = 4;
  localparam int ST_FLAG_BIT = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [3:0] RST_SEL = 4'h0;
  localparam logic [2:0] RST_SRC = 3'h0;

  // ==========================================================
  // Clock source codes and timing
  localparam logic [2:0] CS_PIN_TRUE = 3'h0;
  localparam logic [2:0] CS_PIN_INV = 3'h1;
  localparam logic [2:0] CS_INSTR = 3'h2;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
  localparam logic [14:0] PRE_FULL_MASK = 15'h7FFF;
  localparam logic [3:0] PRE_MAX_SEL = 4'hF;

  // ==========================================================
  // Avalon-MM request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tmc_av_req_t;

  // Complete state of the timer
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] hbuf;
    logic [7:0] pbuf;
    logic en;
    logic wide;
    logic [3:0] post_sel;
    logic [2:0] cs;
    logic unsync;
    logic [3:0] ps_sel;
    logic [14:0] pre_cnt;
    logic [3:0] post_cnt;
    logic pend;
    logic match;
    logic tog;
    logic flag;
    logic [1:0] div;
    logic [7:0] s1;
    logic [7:0] s2;
    logic prev;
    logic ack;
    logic [31:0] rdata;
  } tmc_state_t;

endpackage : tmc_pkg

// >>> rtl/tmc_timer.sv
// Top of the 8/16-bit timer/counter with Avalon-MM register slave
//
// Summary of operation
// - One mode bit picks 8-bit or 16-bit counting.
// - Internal source counts once per instruction cycle, before prescaling.
// - External source counts rising edges after prescaling.
// - 15-bit prescaler, sixteen power-of-two ratios 1:1 to 1:32768.
// - Three-bit clock source field in the second control register.
// - 16-bit mode: reading low count copies true high byte into buffer.
// - 16-bit mode: writing low count loads high byte from buffer.
// - 8-bit match clears count, reloads period buffer, pulses match output once per N events.
// - 8-bit registers readable/writable; reset gives count 00h, period FFh.
// - Prescaler and postscaler clear on low count, control writes, reset.
// - Counter mode adds one per input or prescaler rising edge.
// - Timer mode advances per instruction cycle or prescaled rate.
// - Unsynchronised mode counts every edge and keeps counting in sleep.
// - Synchronised mode steps on instruction cycles; input at most Fosc/4.
// - Prescaler hidden from software, cleared only by register writes and reset.
// - Event on 8-bit period match or 16-bit rollover from FFFFh.
// - Postscaler 1:1 to 1:16 sets the event flag once per N events.
// - Output toggles per postscaled match, readable as bit 5 of first control register.
`timescale 1ns/1ps

module tmc_timer (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire tmc_pkg::tmc_av_req_t i_av,
  output logic [31:0] o_av_readdata,
  output logic o_av_waitrequest,
  input wire logic [7:0] i_src_levels,
  input wire logic i_sleep,
  output logic o_match_pulse,
  output logic o_toggle_output_status,
  output logic o_match_event_flag
);
  import tmc_pkg::*;

  // ==========================================================
  // State
  tmc_state_t st_q;
  tmc_state_t st_d;

  logic src_lvl;
  logic inst_tick;
  logic src_edge;
  logic run;
  logic [14:0] pre_mask;
  logic pre_tick;
  logic adv;
  logic evt;
  logic wr_low;
  logic wr_hbuf;
  logic wr_cz;
  logic wr_co;
  logic wr_st;
  logic rd_first;
  logic [15:0] wide_next;

  // ==========================================================
  // Bus handshake: writes finish at once, reads after one wait cycle
  assign o_av_waitrequest = i_av.read & ~st_q.ack;
  assign o_av_readdata = st_q.rdata;
  assign o_match_pulse = st_q.match;
  assign o_toggle_output_status = st_q.tog;
  assign o_match_event_flag = st_q.flag;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    st_d = st_q;
    wide_next = 16'h0000;
    evt = 1'b0;

    // Two-flop synchronisers on every source pin
    st_d.s1 = i_src_levels;
    st_d.s2 = st_q.s1;

    // Source selection, pin 0 may be inverted
    case (st_q.cs)
      CS_PIN_TRUE: src_lvl = st_q.s2[0];
      CS_PIN_INV: src_lvl = ~st_q.s2[0];
      default: src_lvl = st_q.s2[st_q.cs];
    endcase
    st_d.prev = src_lvl;

    // Instruction cycle is a quarter of the system clock
    inst_tick = (st_q.div == INSTR_DIV_LAST);
    st_d.div = st_q.div + 2'h1;

    // Internal source steps per instruction cycle, pins on rising edges
    if (st_q.cs == CS_INSTR)
    begin
      src_edge = inst_tick;
    end
    else
    begin
      src_edge = src_lvl & ~st_q.prev;
    end

    // Synchronised mode halts in sleep, unsynchronised keeps going
    run = st_q.en & ~(i_sleep & ~st_q.unsync);

    // Prescaler: tick when the selected low bits are all ones
    pre_mask = PRE_FULL_MASK >> (PRE_MAX_SEL - st_q.ps_sel);
    pre_tick = run & src_edge & ((st_q.pre_cnt & pre_mask) == pre_mask);
    if (run & src_edge)
    begin
      st_d.pre_cnt = st_q.pre_cnt + 15'h0001;
    end

    // Count step: direct when unsynchronised, else on instruction cycles
    if (st_q.unsync)
    begin
      adv = pre_tick;
    end
    else
    begin
      adv = run & inst_tick & (pre_tick | st_q.pend);
      if (adv)
      begin
        st_d.pend = 1'b0;
      end
      else if (pre_tick)
      begin
        st_d.pend = 1'b1;
      end
    end

    // Software clear of the flag, a same-cycle event still sets it
    wr_st = i_av.write & i_av.byteenable[0] & (i_av.address == OFS_STATUS);
    if (wr_st & i_av.writedata[ST_FLAG_BIT])
    begin
      st_d.flag = 1'b0;
    end

    // Match pulse lasts one prescaled period
    if (adv)
    begin
      st_d.match = 1'b0;
      if (st_q.wide)
      begin
        wide_next = {st_q.high, st_q.low} + 16'h0001;
        st_d.high = wide_next[15:8];
        st_d.low = wide_next[7:0];
        evt = ({st_q.high, st_q.low} == 16'hFFFF);
      end
      else if (st_q.low == st_q.pbuf)
      begin
        st_d.low = RST_COUNT;
        st_d.pbuf = st_q.hbuf;
        evt = 1'b1;
      end
      else
      begin
        st_d.low = st_q.low + 8'h01;
      end
    end

    // Postscaler divides events by select plus one
    if (evt)
    begin
      if (st_q.post_cnt == st_q.post_sel)
      begin
        st_d.post_cnt = 4'h0;
        st_d.match = 1'b1;
        st_d.flag = 1'b1;
        st_d.tog = ~st_q.tog;
      end
      else
      begin
        st_d.post_cnt = st_q.post_cnt + 4'h1;
      end
    end

    // Register writes override counting in the same cycle
    wr_low = i_av.write & i_av.byteenable[0] & (i_av.address == OFS_COUNT_LOW);
    wr_hbuf = i_av.write & i_av.byteenable[0] & (i_av.address == OFS_PERIOD_HBUF);
    wr_cz = i_av.write & i_av.byteenable[0] & (i_av.address == OFS_CTRL_ZERO);
    wr_co = i_av.write & i_av.byteenable[0] & (i_av.address == OFS_CTRL_ONE);

    // Low count write, with coherent high-byte load in wide mode
    if (wr_low)
    begin
      st_d.low = i_av.writedata[7:0];
      if (st_q.wide)
      begin
        st_d.high = st_q.hbuf;
      end
    end

    // Period register or high-byte buffer
    if (wr_hbuf)
    begin
      st_d.hbuf = i_av.writedata[7:0];
    end

    // First control register
    if (wr_cz)
    begin
      st_d.en = i_av.writedata[CZ_ENABLE_BIT];
      st_d.wide = i_av.writedata[CZ_WIDE_BIT];
      st_d.post_sel = i_av.writedata[3:0];
    end

    // Second control register
    if (wr_co)
    begin
      st_d.cs = i_av.writedata[CO_SRC_LSB+2:CO_SRC_LSB];
      st_d.unsync = i_av.writedata[CO_UNSYNC_BIT];
      st_d.ps_sel = i_av.writedata[3:0];
    end

    // Hidden dividers cleared by these writes
    if (wr_low | wr_cz | wr_co)
    begin
      st_d.pre_cnt = 15'h0000;
      st_d.post_cnt = 4'h0;
      st_d.pend = 1'b0;
    end

    // Read: capture data in the wait cycle, release next cycle
    rd_first = i_av.read & ~st_q.ack;
    if (rd_first)
    begin
      st_d.ack = 1'b1;
      case (i_av.address)
        OFS_COUNT_LOW:
        begin
          st_d.rdata = {24'h000000, st_q.low};
          if (st_q.wide)
          begin
            st_d.hbuf = st_q.high;
          end
        end
        OFS_PERIOD_HBUF: st_d.rdata = {24'h000000, st_q.hbuf};
        OFS_CTRL_ZERO: st_d.rdata = {24'h000000, st_q.en, 1'b0, st_q.tog, st_q.wide, st_q.post_sel};
        OFS_CTRL_ONE: st_d.rdata = {24'h000000, st_q.cs, st_q.unsync, st_q.ps_sel};
        OFS_STATUS: st_d.rdata = {31'h00000000, st_q.flag};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
    else
    begin
      st_d.ack = 1'b0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_q.low <= RST_COUNT;
      st_q.high <= RST_COUNT;
      st_q.hbuf <= RST_PERIOD;
      st_q.pbuf <= RST_PERIOD;
      st_q.en <= 1'b0;
      st_q.wide <= 1'b0;
      st_q.post_sel <= RST_SEL;
      st_q.cs <= RST_SRC;
      st_q.unsync <= 1'b0;
      st_q.ps_sel <= RST_SEL;
      st_q.pre_cnt <= 15'h0000;
      st_q.post_cnt <= 4'h0;
      st_q.pend <= 1'b0;
      st_q.match <= 1'b0;
      st_q.tog <= 1'b0;
      st_q.flag <= 1'b0;
      st_q.div <= 2'h0;
      st_q.s1 <= 8'h00;
      st_q.s2 <= 8'h00;
      st_q.prev <= 1'b0;
      st_q.ack <= 1'b0;
      st_q.rdata <= 32'h00000000;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule : tmc_timer

// >>> tb/tmc_timer_monitor.sv
// Port-level concurrent checks of the timer/counter
`timescale 1ns/1ps
module tmc_timer_monitor
  import tmc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire tmc_pkg::tmc_av_req_t i_av,
  input wire logic [31:0] o_av_readdata,
  input wire logic o_av_waitrequest,
  input wire logic [7:0] i_src_levels,
  input wire logic i_sleep,
  input wire logic o_match_pulse,
  input wire logic o_toggle_output_status,
  input wire logic o_match_event_flag
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  logic clr_wr;
  logic rd_done;
  // Status write and read completion
  assign clr_wr = i_av.write && i_av.address == OFS_STATUS;
  assign rd_done = i_av.read && !o_av_waitrequest;
  // ==========================================================
  // Bus timing and read data
  property p_write_nowait; i_av.write |-> !o_av_waitrequest; endproperty
  a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
  property p_read_wait; i_av.read && o_av_waitrequest |=> !o_av_waitrequest; endproperty
  a_read_wait: assert property (p_read_wait) else $error("read not one wait");
  property p_unmapped; rd_done && i_av.address > OFS_STATUS |-> o_av_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_upper; rd_done |-> o_av_readdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // ==========================================================
  // Event, flag and toggle output
  property p_tog_event; $rose(o_match_pulse) |-> $changed(o_toggle_output_status); endproperty
  a_tog_event: assert property (p_tog_event) else $error("no toggle on event");
  property p_tog_cause; $changed(o_toggle_output_status) |-> o_match_pulse; endproperty
  a_tog_cause: assert property (p_tog_cause) else $error("toggle without event");
  property p_flag_event; $rose(o_match_pulse) |-> o_match_event_flag; endproperty
  a_flag_event: assert property (p_flag_event) else $error("flag not set on event");
  property p_flag_rise; $rose(o_match_event_flag) |-> o_match_pulse; endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag set without event");
  property p_flag_clr;
    clr_wr && i_av.writedata[0] && i_av.byteenable[0] && !o_match_pulse |=>
      !o_match_event_flag || $rose(o_match_pulse);
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_flag_sticky; $fell(o_match_event_flag) |-> $past(clr_wr); endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell alone");
  // Main scenarios reached
  c_event: cover property ($rose(o_match_pulse));
  c_clear: cover property ($fell(o_match_event_flag));
  c_read: cover property (rd_done);
endmodule : tmc_timer_monitor

bind tmc_timer tmc_timer_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_av(i_av),
  .o_av_readdata(o_av_readdata), .o_av_waitrequest(o_av_waitrequest), .i_src_levels(i_src_levels),
  .i_sleep(i_sleep), .o_match_pulse(o_match_pulse), .o_toggle_output_status(o_toggle_output_status),
  .o_match_event_flag(o_match_event_flag));

// >>> tb/tmc_timer_tb.sv
// Self-checking bench of the timer/counter over Avalon-MM
`timescale 1ns/1ps
module tb_top;
  import tmc_pkg::*;
  logic i_sys_clk, i_rstn, i_sleep, o_av_waitrequest, o_match_pulse, o_toggle_output_status, o_match_event_flag;
  tmc_av_req_t i_av;
  logic [31:0] o_av_readdata;
  logic [7:0] i_src_levels;
  logic [15:0] lf;
  logic [31:0] exp_q[$];
  int fails, num_checks;
  tmc_timer u_dut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_av(i_av), .o_av_readdata(o_av_readdata),
    .o_av_waitrequest(o_av_waitrequest), .i_src_levels(i_src_levels), .i_sleep(i_sleep),
    .o_match_pulse(o_match_pulse), .o_toggle_output_status(o_toggle_output_status),
    .o_match_event_flag(o_match_event_flag));
  // ==========================================================
  // Clock, watchdog and helpers
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  initial
  begin
    repeat (5000) @(posedge i_sys_clk);
    fails++;
    final_report();
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic av_wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_av <= '{read: 1'b0, write: 1'b1, address: a, writedata: {24'h0, d}, byteenable: 4'hF};
    do @(posedge i_sys_clk); while (o_av_waitrequest !== 1'b0);
    i_av.write <= 1'b0;
  endtask : av_wr
  task automatic av_rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    @(posedge i_sys_clk);
    i_av <= '{read: 1'b1, write: 1'b0, address: a, writedata: 32'h0, byteenable: 4'hF};
    do @(posedge i_sys_clk); while (o_av_waitrequest !== 1'b0);
    i_av.read <= 1'b0;
  endtask : av_rd
  // Pin pulses, slow enough for the synchroniser; spare pins random
  task automatic pulses(input int n);
    repeat (2 * n)
    begin
      lf = lfsr_next(lf);
      i_src_levels <= {lf[7:1], ~i_src_levels[0]};
      repeat (8) @(posedge i_sys_clk);
    end
  endtask : pulses
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report
  // Compare each completed read with the oldest noted value
  always @(posedge i_sys_clk)
    if (i_av.read === 1'b1 && o_av_waitrequest === 1'b0)
      check($sformatf("reg %h", i_av.address), o_av_readdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  // ==========================================================
  // Main sequence
  initial
  begin
    i_rstn = 1'b0;
    i_sleep = 1'b0;
    i_src_levels = 8'h00;
    i_av = '0;
    lf = 16'h1FC5;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    av_rd(OFS_COUNT_LOW, RST_COUNT);
    av_rd(OFS_PERIOD_HBUF, RST_PERIOD);
    av_rd(OFS_CTRL_ZERO, 8'h00);
    av_rd(OFS_CTRL_ONE, 8'h00);
    av_rd(5'h14, 8'h00);
    $display("test reset done");
    lf = lfsr_next(lf);
    av_wr(OFS_CTRL_ZERO, 8'h10);
    av_wr(OFS_PERIOD_HBUF, lf[15:8]);
    av_wr(OFS_COUNT_LOW, lf[7:0]);
    av_wr(OFS_PERIOD_HBUF, ~lf[15:8]);
    av_rd(OFS_COUNT_LOW, lf[7:0]);
    av_rd(OFS_PERIOD_HBUF, lf[15:8]);
    $display("test wide access done");
    av_wr(OFS_CTRL_ZERO, 8'h90);
    av_wr(OFS_PERIOD_HBUF, 8'hFF);
    av_wr(OFS_COUNT_LOW, 8'hFE);
    pulses(2);
    av_rd(OFS_COUNT_LOW, 8'h00);
    av_rd(OFS_PERIOD_HBUF, 8'h00);
    av_rd(OFS_STATUS, 8'h01);
    av_rd(OFS_CTRL_ZERO, 8'hB0);
    av_wr(OFS_STATUS, 8'h01);
    av_rd(OFS_STATUS, 8'h00);
    av_wr(OFS_CTRL_ZERO, 8'h91);
    repeat (2)
    begin
      av_wr(OFS_PERIOD_HBUF, 8'hFF);
      av_wr(OFS_COUNT_LOW, 8'hFE);
      pulses(2);
    end
    av_rd(OFS_STATUS, 8'h00);
    $display("test rollover done");
    av_wr(OFS_CTRL_ZERO, 8'h80);
    av_wr(OFS_CTRL_ONE, 8'h01);
    av_wr(OFS_COUNT_LOW, 8'h00);
    pulses(6);
    av_rd(OFS_COUNT_LOW, 8'h03);
    i_sleep <= 1'b1;
    av_wr(OFS_CTRL_ONE, 8'h30);
    av_wr(OFS_COUNT_LOW, 8'h00);
    pulses(4);
    av_rd(OFS_COUNT_LOW, 8'h04);
    av_wr(OFS_CTRL_ONE, 8'h20);
    pulses(3);
    av_rd(OFS_COUNT_LOW, 8'h04);
    av_wr(OFS_CTRL_ONE, 8'h40);
    av_wr(OFS_COUNT_LOW, 8'h00);
    repeat (40) @(posedge i_sys_clk);
    av_rd(OFS_COUNT_LOW, 8'h00);
    $display("test prescale and sleep done");
    // Internal clock, 8-bit: old period FF matches first, then period 03
    av_wr(OFS_PERIOD_HBUF, 8'h03);
    av_wr(OFS_COUNT_LOW, 8'hFE);
    i_sleep <= 1'b0;
    repeat (20) @(posedge i_sys_clk);
    i_sleep <= 1'b1;
    av_rd(OFS_COUNT_LOW, 8'h03);
    av_rd(OFS_CTRL_ZERO, 8'h80);
    check("match pin", {31'h0, o_match_pulse}, 32'h0);
    check("flag pin", {31'h0, o_match_event_flag}, 32'h1);
    av_wr(OFS_STATUS, 8'h01);
    av_rd(OFS_STATUS, 8'h00);
    i_sleep <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_sleep <= 1'b1;
    av_rd(OFS_COUNT_LOW, 8'h00);
    av_rd(OFS_PERIOD_HBUF, 8'h03);
    av_rd(OFS_CTRL_ZERO, 8'hA0);
    check("match pin", {31'h0, o_match_pulse}, 32'h1);
    check("toggle pin", {31'h0, o_toggle_output_status}, 32'h1);
    check("flag pin", {31'h0, o_match_event_flag}, 32'h1);
    $display("test period match done");
    // Source code 3 follows pin 3; six toggles give three rising edges
    av_wr(OFS_CTRL_ONE, 8'h70);
    av_wr(OFS_COUNT_LOW, 8'h00);
    repeat (6)
    begin
      i_src_levels <= i_src_levels ^ 8'h08;
      repeat (8) @(posedge i_sys_clk);
    end
    av_rd(OFS_COUNT_LOW, 8'h03);
    $display("test pin source done");
    // Reset in mid-run returns registers and pins to reset values
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    check("match pin", {31'h0, o_match_pulse}, 32'h0);
    check("toggle pin", {31'h0, o_toggle_output_status}, 32'h0);
    check("flag pin", {31'h0, o_match_event_flag}, 32'h0);
    av_rd(OFS_COUNT_LOW, RST_COUNT);
    av_rd(OFS_PERIOD_HBUF, RST_PERIOD);
    av_rd(OFS_CTRL_ONE, 8'h00);
    av_rd(OFS_STATUS, 8'h00);
    i_sleep <= 1'b0;
    $display("test mid-run reset done");
    repeat (4) @(posedge i_sys_clk);
    final_report();
  end
endmodule : tb_top
